/* hdl/issel_top.sv */
/*
 Interrupt shadow set select block with an AXI4-Lite register slave.
 Assumes one clock (aclk, 25 MHz), synchronous active-low reset, and a
 core that pulses entry_valid with the accepted priority level.
*/
`timescale 1ns/1ns
module issel_top
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [3:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   // AXI4-Lite write response
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // AXI4-Lite read address
   input wire logic [3:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   // AXI4-Lite read data
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Core interrupt entry
   input wire logic entry_valid,
   input wire logic [2:0] entry_level,
   output logic set_valid_r,
   output logic set_use_shadow_r,
   output logic [3:0] set_num_r
);
   logic [31:0] map_r, map_nxt;
   logic multi_vec_r, multi_vec_nxt;
   logic [3:0] awaddr_r;
   logic aw_have_r, w_have_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [7:0] entry_cnt_r;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction

   // Write channel: address and data taken independently
   wire aw_take = s_awvalid && s_awready;
   wire w_take = s_wvalid && s_wready;
   wire wr_go = aw_have_r && w_have_r && !s_bvalid;
   // Next states feed the ready flops, so ready is a plain register output
   wire aw_have_nxt = aw_take || (aw_have_r && !wr_go);
   wire w_have_nxt = w_take || (w_have_r && !wr_go);
   wire bvalid_nxt = wr_go || (s_bvalid && !s_bready);
   wire wr_map = wr_go && awaddr_r == issel_pkg::ISSEL_OFS_MAP;
   wire wr_ctrl = wr_go && awaddr_r == issel_pkg::ISSEL_OFS_CTRL;
   wire wr_ok = wr_map || wr_ctrl;
   wire [31:0] map_merged = merge(map_r, wdata_r, wstrb_r);
   wire [31:0] ctrl_word = {19'h0, multi_vec_r, 12'h0};
   wire [31:0] ctrl_merged = merge(ctrl_word, wdata_r, wstrb_r);

   // Unimplemented bits never store, so they read zero
   assign map_nxt = wr_map ? (map_merged & issel_pkg::ISSEL_MAP_WMASK) : map_r;
   assign multi_vec_nxt = wr_ctrl ? ctrl_merged[issel_pkg::ISSEL_POS_MULTI_VEC] : multi_vec_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         map_r <= issel_pkg::ISSEL_MAP_RST;
         multi_vec_r <= issel_pkg::ISSEL_MULTI_VEC_RST;
      end
      else
      begin
         map_r <= map_nxt;
         multi_vec_r <= multi_vec_nxt;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= issel_pkg::ISSEL_RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_have_r <= 1'b1;
            awaddr_r <= {s_awaddr[3:2], 2'h0};
         end
         else if (wr_go)
            aw_have_r <= 1'b0;
         if (w_take)
         begin
            w_have_r <= 1'b1;
            wdata_r <= s_wdata;
            wstrb_r <= s_wstrb;
         end
         else if (wr_go)
            w_have_r <= 1'b0;
         if (wr_go)
         begin
            s_bvalid <= 1'b1;
            s_bresp <= wr_ok ? issel_pkg::ISSEL_RESP_OKAY : issel_pkg::ISSEL_RESP_SLVERR;
         end
         else if (s_bready)
            s_bvalid <= 1'b0;
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_awready <= 1'b1;
         s_wready <= 1'b1;
      end
      else
      begin
         s_awready <= !aw_have_nxt && !bvalid_nxt;
         s_wready <= !w_have_nxt && !bvalid_nxt;
      end
   end

   // Read channel
   wire ar_take = s_arvalid && s_arready;
   wire [3:0] ar_word = {s_araddr[3:2], 2'h0};
   wire rd_map = ar_word == issel_pkg::ISSEL_OFS_MAP;
   wire rd_ctrl = ar_word == issel_pkg::ISSEL_OFS_CTRL;
   wire rd_stat = ar_word == issel_pkg::ISSEL_OFS_STAT;
   wire [31:0] stat_word = {19'h0, set_use_shadow_r, set_num_r, entry_cnt_r};
   wire [31:0] rd_data = rd_map ? map_r : rd_ctrl ? ctrl_word : rd_stat ? stat_word : 32'h0000_0000;
   wire rvalid_nxt = ar_take || (s_rvalid && !s_rready);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_arready <= 1'b1;
      else
         s_arready <= !rvalid_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= issel_pkg::ISSEL_RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_rvalid <= 1'b1;
         s_rdata <= rd_data;
         s_rresp <= (rd_map || rd_ctrl || rd_stat) ? issel_pkg::ISSEL_RESP_OKAY : issel_pkg::ISSEL_RESP_SLVERR;
      end
      else if (s_rready)
         s_rvalid <= 1'b0;
   end

   // Set selection
   wire sel_use;
   wire [3:0] sel_num;
   issel_select u_select
   (
      .map_reg(map_r),
      .multi_vector_enable(multi_vec_r),
      .level(entry_level),
      .use_shadow(sel_use),
      .set_num(sel_num)
   );

   // Registered answer one cycle after entry; set_valid_r pulses one cycle, set_use_shadow_r and set_num_r held until the next entry
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         set_valid_r <= 1'b0;
         set_use_shadow_r <= 1'b0;
         set_num_r <= issel_pkg::ISSEL_SET0;
         entry_cnt_r <= 8'h00;
      end
      else
      begin
         set_valid_r <= entry_valid;
         if (entry_valid)
         begin
            set_use_shadow_r <= sel_use;
            set_num_r <= sel_num;
            entry_cnt_r <= entry_cnt_r + 8'h01;
         end
      end
   end

   // Assertions
   reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      map_r[3:1] == 3'h0) else $error("map reserved bits not zero");
   field_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_map && wstrb_r == 4'hF |=> map_r[23:4] == $past(wdata_r[23:4]))
      else $error("level fields not stored");
   multi_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
      entry_valid && multi_vec_r && entry_level == 3'h3 |=> set_num_r == $past(map_r[15:12]) && set_use_shadow_r)
      else $error("level 3 set wrong");
   lvl1_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
      entry_valid && multi_vec_r && entry_level == 3'h1 && map_r[7:4] == 4'h1 |=> set_num_r == 4'h1)
      else $error("level 1 set 1 wrong");
   lvl5_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      entry_valid && multi_vec_r && entry_level == 3'h5 && map_r[23:20] == 4'h0 |=> set_num_r == 4'h0)
      else $error("level 5 set 0 wrong");
   single_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
      entry_valid && !multi_vec_r |=> set_use_shadow_r == $past(map_r[0]))
      else $error("single vector shadow wrong");
   fields_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
      entry_valid && !multi_vec_r && !map_r[0] |=> set_num_r == 4'h0 && !set_use_shadow_r)
      else $error("fields used without multi vector");
   entry_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      entry_valid |=> set_valid_r ##1 (set_valid_r == $past(entry_valid)))
      else $error("entry answer timing wrong");
   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go |=> s_bvalid) else $error("no write response");
   cover_multi_entry: cover property (@(posedge aclk) entry_valid && multi_vec_r);
   cover_sv_entry: cover property (@(posedge aclk) entry_valid && !multi_vec_r && map_r[0]);
   cover_write_map: cover property (@(posedge aclk) wr_map);
   cover_read_stat: cover property (@(posedge aclk) ar_take && rd_stat);
endmodule // issel_top

/* hdl/issel_pkg.sv */
/*
 Package for the interrupt shadow set select block: register offsets,
 field positions, reset values and codes.
 Assumes nothing of its surroundings.
*/
package issel_pkg;
   // Register offsets (byte addresses)
   localparam logic [3:0] ISSEL_OFS_MAP = 4'h0;
   localparam logic [3:0] ISSEL_OFS_CTRL = 4'h4;
   localparam logic [3:0] ISSEL_OFS_STAT = 4'h8;
   // Field positions in the map register
   localparam int ISSEL_POS_SV_EN = 0;
   localparam int ISSEL_POS_LVL1 = 4;
   localparam int ISSEL_FIELD_W = 4;
   localparam int ISSEL_NUM_LVL = 5;
   // Field position in the control register
   localparam int ISSEL_POS_MULTI_VEC = 12;
   // Reset values
   localparam logic [31:0] ISSEL_MAP_RST = 32'h0000_0000;
   localparam logic ISSEL_MULTI_VEC_RST = 1'h0;
   // Writable bits of the map register: fields 23..4 and bit 0
   localparam logic [31:0] ISSEL_MAP_WMASK = 32'h00FF_FFF1;
   // Shadow set codes
   localparam logic [3:0] ISSEL_SET0 = 4'h0;
   localparam logic [3:0] ISSEL_SET1 = 4'h1;
   // AXI responses
   localparam logic [1:0] ISSEL_RESP_OKAY = 2'h0;
   localparam logic [1:0] ISSEL_RESP_SLVERR = 2'h2;
endpackage

/* hdl/issel_select.sv */
/*
 Shadow set selection from the map register, the multi-vector enable and
 the accepted interrupt's priority level. Purely combinational.
 Assumes the level is 0..7; levels 6, 7 and 0 have no field here.
*/
`timescale 1ns/1ns
module issel_select
(
   // Configuration
   input wire logic [31:0] map_reg,
   input wire logic multi_vector_enable,
   // Accepted interrupt
   input wire logic [2:0] level,
   // Result
   output logic use_shadow,
   output logic [3:0] set_num
);
   logic [3:0] field [0:7];
   wire [3:0] lvl_field;

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_field
         if (g >= 1 && g <= issel_pkg::ISSEL_NUM_LVL)
         begin : g_impl
            // Level g field at bits 4g+3..4g
            assign field[g] = map_reg[issel_pkg::ISSEL_POS_LVL1 + (g - 1) * issel_pkg::ISSEL_FIELD_W +: 4];
         end
         else
         begin : g_none
            assign field[g] = issel_pkg::ISSEL_SET0;
         end
      end
   endgenerate

   assign lvl_field = field[level];
   // Per-level fields only count in multi-vector mode
   always_comb
   begin
      if (multi_vector_enable)
      begin
         use_shadow = 1'b1;
         set_num = lvl_field;
      end
      else
      begin
         use_shadow = map_reg[issel_pkg::ISSEL_POS_SV_EN];
         set_num = map_reg[issel_pkg::ISSEL_POS_SV_EN] ? issel_pkg::ISSEL_SET1 : issel_pkg::ISSEL_SET0;
      end
   end
endmodule // issel_select

/* testbench/issel_core_model.sv */
/*
 Core-side model: raises one-cycle interrupt entry pulses with a level.
 Assumes the block samples entry_valid on each rising aclk edge.
*/
`timescale 1ns/1ns
module issel_core_model
(
   // Clock
   input wire logic aclk,
   // Entry request
   output logic entry_valid,
   output logic [2:0] entry_level
);
   initial
   begin
      entry_valid = 1'b0;
      entry_level = 3'h0;
   end
   // Gap models a slow core; level is scrambled once the pulse ends
   task automatic enter(input logic [2:0] lvl, input int gap);
      repeat (gap) @(posedge aclk);
      @(posedge aclk);
      entry_valid <= 1'b1;
      entry_level <= lvl;
      @(posedge aclk);
      entry_valid <= 1'b0;
      entry_level <= ~lvl;
   endtask
endmodule // issel_core_model

/* testbench/interrupt_shadow_set_select_test.sv */
/*
 Testbench: AXI4-Lite register access and entry checks of issel_top.
 Assumes issel_pkg and issel_core_model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module interrupt_shadow_set_select_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic [31:0] s_wdata = 32'h0, s_rdata;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic entry_valid, set_valid_r, set_use_shadow_r;
   logic [2:0] entry_level;
   logic [3:0] set_num_r;
   logic [31:0] map;
   int fails = 0;
   int samples_checked = 0;
   always #20 aclk = ~aclk;
   issel_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
      .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .entry_valid(entry_valid),
      .entry_level(entry_level), .set_valid_r(set_valid_r), .set_use_shadow_r(set_use_shadow_r),
      .set_num_r(set_num_r));
   issel_core_model core_u (.aclk(aclk), .entry_valid(entry_valid), .entry_level(entry_level));
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= s;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (s_awready === 1'b1) aw_ok = 1'b1;
         if (s_wready === 1'b1) w_ok = 1'b1;
         if (aw_ok) s_awvalid <= 1'b0;
         if (w_ok) s_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (s_bvalid !== 1'b1);
      s_bready <= 1'b0;
      `CHK(s_bresp, er)
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge aclk); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge aclk); while (s_rvalid !== 1'b1);
      s_rready <= 1'b0;
      `CHK(s_rdata, ed)
      `CHK(s_rresp, er)
   endtask
   // Result must appear exactly one cycle after the sampled pulse
   task automatic ent(input logic [2:0] lvl, input logic eu, input logic [3:0] en);
      core_u.enter(lvl, lvl % 2);
      #1;
      `CHK(set_valid_r, 1'b1)
      `CHK(set_use_shadow_r, eu)
      `CHK(set_num_r, en)
      @(posedge aclk);
      #1;
      `CHK(set_valid_r, 1'b0)
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge aclk);
      fails++;
      wrap_up;
   end
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(issel_pkg::ISSEL_OFS_MAP, issel_pkg::ISSEL_MAP_RST, issel_pkg::ISSEL_RESP_OKAY);
      rd(issel_pkg::ISSEL_OFS_CTRL, 32'h0000_0000, issel_pkg::ISSEL_RESP_OKAY);
      // Only codes 0000 and 0001 are ever written to the level fields
      wr(issel_pkg::ISSEL_OFS_MAP, 32'h1111_111F, 4'hF, issel_pkg::ISSEL_RESP_OKAY);
      rd(issel_pkg::ISSEL_OFS_MAP, 32'h0011_1111, issel_pkg::ISSEL_RESP_OKAY);
      wr(issel_pkg::ISSEL_OFS_MAP, 32'h0000_0000, 4'h2, issel_pkg::ISSEL_RESP_OKAY);
      rd(issel_pkg::ISSEL_OFS_MAP, 32'h0011_0011, issel_pkg::ISSEL_RESP_OKAY);
      wr(4'hC, 32'hFFFF_FFFF, 4'hF, issel_pkg::ISSEL_RESP_SLVERR);
      rd(4'hC, 32'h0000_0000, issel_pkg::ISSEL_RESP_SLVERR);
      ent(3'h3, 1'b1, issel_pkg::ISSEL_SET1);
      wr(issel_pkg::ISSEL_OFS_MAP, 32'h0011_1110, 4'hF, issel_pkg::ISSEL_RESP_OKAY);
      ent(3'h1, 1'b0, issel_pkg::ISSEL_SET0);
      wr(issel_pkg::ISSEL_OFS_CTRL, 32'h0000_1000, 4'hF, issel_pkg::ISSEL_RESP_OKAY);
      rd(issel_pkg::ISSEL_OFS_CTRL, 32'h0000_1000, issel_pkg::ISSEL_RESP_OKAY);
      for (int m = 0; m < 2; m++)
      begin
         map = (m == 0) ? 32'h0010_1010 : 32'h0001_0100;
         wr(issel_pkg::ISSEL_OFS_MAP, map, 4'hF, issel_pkg::ISSEL_RESP_OKAY);
         for (int l = 0; l < 8; l++)
            ent(l[2:0], 1'b1, (l >= 1 && l <= 5) ? map[l * 4 +: 4] : 4'h0);
      end
      rd(issel_pkg::ISSEL_OFS_STAT, 32'h0000_1012, issel_pkg::ISSEL_RESP_OKAY);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(issel_pkg::ISSEL_OFS_MAP, issel_pkg::ISSEL_MAP_RST, issel_pkg::ISSEL_RESP_OKAY);
      rd(issel_pkg::ISSEL_OFS_CTRL, 32'h0000_0000, issel_pkg::ISSEL_RESP_OKAY);
      wrap_up;
   end
endmodule // interrupt_shadow_set_select_test
